/* common/incond_pkg.sv */
// constants, register map and control layout for the input conditioning block
package incond_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;     // control word
  localparam logic [7:0] OFF_STATUS = 8'h04;   // unit status
  localparam logic [7:0] OFF_CNT_ERR = 8'h08;  // counter error flags
  localparam logic [7:0] OFF_DISC_ERR = 8'h0c; // disconnection flags
  localparam logic [7:0] OFF_INPUT = 8'h10;    // conditioned channel values
  localparam logic [7:0] OFF_THRESH = 8'h40;   // threshold block, one word a channel
  localparam logic [7:0] OFF_COUNT = 8'h80;    // counter block, one word a channel

  // ----------------------------------------
  // control word layout
  // ----------------------------------------
  typedef struct packed {
    logic valve_unit;   // bit 9: unit drives valves, short save interval
    logic supply_short_detect_enable; // bit 8
    logic disconnect_detect_enable;   // bit 7
    logic counter_enable;             // bit 6
    logic inrush_enable;              // bit 5
    logic [1:0] stretch_sel;          // bits 4:3
    logic [1:0] filter_sel;           // bits 2:1
    logic restart;                    // bit 0 reserved, reads zero
  } ctrl_s;

  localparam int CTRL_W = 10;
  // reset: filter 1.0 ms (code 1), stretch 15 ms (code 1), options off
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h00a;

  // ----------------------------------------
  // timing, times in microseconds and seconds
  // ----------------------------------------
  localparam int CLK_NS = 10;          // pclk period
  localparam int TICK_US = 100;        // base tick, 0.1 ms
  localparam int TICK_CYCLES = TICK_US * 1000 / CLK_NS;
  localparam int FILT0_US = 100;
  localparam int FILT1_US = 1000;
  localparam int FILT2_US = 10000;
  localparam int FILT3_US = 20000;
  localparam int STR0_US = 1000;
  localparam int STR1_US = 15000;
  localparam int STR2_US = 100000;
  localparam int STR3_US = 200000;
  localparam int INRUSH_US = 100000;
  localparam int SAVE_VALVE_S = 30;
  localparam int SAVE_INPUT_S = 3600;
  localparam int INRUSH_TICKS = INRUSH_US / TICK_US;
  localparam int SAVE_VALVE_TICKS = SAVE_VALVE_S * 1000000 / TICK_US;
  localparam int SAVE_INPUT_TICKS = SAVE_INPUT_S * 10000;

  // ----------------------------------------
  // threshold scaling and limits
  // ----------------------------------------
  localparam int THR_W = 16;
  localparam logic [25:0] THR_SCALE = 26'd1000;
  localparam logic [THR_W-1:0] THR_MAX = 16'd65000;
  localparam logic [THR_W-1:0] THR_MIN = 16'd1;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_SAVE} seq_e;

endpackage : incond_pkg

/* rtl/input_conditioning_counter.sv */
// input filtering, pulse stretching, inrush blanking and saved ON-event counters
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module input_conditioning_counter
#(
  parameter int N = 8,                  // channels
  parameter int AW = 3,                 // channel index width
  parameter bit HAS_DISC_HW = 1'b1,     // unit has disconnection sensing
  parameter int TICK_CYCLES = incond_pkg::TICK_CYCLES,
  parameter int SAVE_VALVE_TICKS = incond_pkg::SAVE_VALVE_TICKS,
  parameter int SAVE_INPUT_TICKS = incond_pkg::SAVE_INPUT_TICKS
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // field side
  input wire logic [N-1:0] in_pins,
  input wire logic overcurrent_in,
  input wire logic [N-1:0] disc_sense,
  // conditioned results
  output logic [N-1:0] chan_value,
  output logic overcurrent_err,
  // non-volatile store
  output logic nv_req,
  output logic nv_we,
  output logic [AW-1:0] nv_addr,
  output logic [31:0] nv_wdata,
  input wire logic nv_ack,
  input wire logic [31:0] nv_rdata
);

  // ----------------------------------------
  // control register and apb decode
  // ----------------------------------------
  incond_pkg::ctrl_s ctrl_r, ctrl_nxt; // software control word
  logic wr_en; // write in access phase
  logic [N-1:0] cnt_err_r, cnt_err_nxt; // counter error flags
  logic [N-1:0] disc_err_r, disc_err_nxt; // disconnection flags
  logic [N-1:0][31:0] count_r, count_nxt; // ON-event counters
  incond_pkg::seq_e seq_r, seq_nxt; // load/run/save sequencer

  // register block check, used by read and write decode
  function automatic logic in_block(input logic [7:0] a, input logic [7:0] base);
    in_block = (a >= base) && (a < base + 8'(4 * N)) && (a[1:0] == 2'b00);
  endfunction : in_block

  assign pready = 1'b1; // zero wait states
  assign wr_en = psel && penable && pwrite;

  // unmapped or misaligned access answers with an error
  always_comb
  begin
    pslverr = 1'b0;
    if (psel && penable)
    begin
      if (!(paddr == incond_pkg::OFF_CTRL || paddr == incond_pkg::OFF_STATUS ||
            paddr == incond_pkg::OFF_CNT_ERR || paddr == incond_pkg::OFF_DISC_ERR ||
            paddr == incond_pkg::OFF_INPUT || in_block(paddr, incond_pkg::OFF_THRESH) ||
            in_block(paddr, incond_pkg::OFF_COUNT)))
      begin
        pslverr = 1'b1;
      end
    end
  end

  // read mux, thresholds are write-only and read zero
  always_comb
  begin
    prdata = 32'h0;
    if (psel && !pwrite)
    begin
      case (paddr)
        incond_pkg::OFF_CTRL: prdata = {22'h0, ctrl_r[incond_pkg::CTRL_W-1:1], 1'b0};
        incond_pkg::OFF_STATUS: prdata = {29'h0, seq_r == incond_pkg::ST_SAVE,
                                         seq_r != incond_pkg::ST_LOAD, overcurrent_err};
        incond_pkg::OFF_CNT_ERR: prdata = 32'(cnt_err_r);
        incond_pkg::OFF_DISC_ERR: prdata = 32'(disc_err_r);
        incond_pkg::OFF_INPUT: prdata = 32'(chan_value);
        default:
        begin
          if (in_block(paddr, incond_pkg::OFF_COUNT))
          begin
            prdata = count_r[paddr[AW+1:2]];
          end
        end
      endcase
    end
  end

  // control word next value
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_en && paddr == incond_pkg::OFF_CTRL)
    begin
      ctrl_nxt = incond_pkg::ctrl_s'(pwdata[incond_pkg::CTRL_W-1:0]);
      ctrl_nxt.restart = 1'b0;
      ctrl_nxt.disconnect_detect_enable = pwdata[7] & HAS_DISC_HW;
    end
  end

  // control register, defaults 1.0 ms filter and 15 ms stretch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= incond_pkg::ctrl_s'(incond_pkg::CTRL_RESET);
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ----------------------------------------
  // 0.1 ms tick divider
  // ----------------------------------------
  logic [31:0] div_r, div_nxt; // cycle count within a tick
  logic tick; // one-cycle enable every 0.1 ms

  assign tick = (div_r == 32'(TICK_CYCLES - 1));

  // wrap at the tick length
  always_comb
  begin
    div_nxt = tick ? 32'h0 : div_r + 32'h1;
  end

  // divider register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_r <= 32'h0;
    end
    else
    begin
      div_r <= div_nxt;
    end
  end

  // ----------------------------------------
  // selected times in ticks
  // ----------------------------------------
  logic [7:0] filt_ticks; // stable time required
  logic [10:0] str_ticks; // hold time from an accepted rising edge

  // filter and stretch choice
  always_comb
  begin
    case (ctrl_r.filter_sel)
      2'd0: filt_ticks = 8'(incond_pkg::FILT0_US / incond_pkg::TICK_US);
      2'd1: filt_ticks = 8'(incond_pkg::FILT1_US / incond_pkg::TICK_US);
      2'd2: filt_ticks = 8'(incond_pkg::FILT2_US / incond_pkg::TICK_US);
      default: filt_ticks = 8'(incond_pkg::FILT3_US / incond_pkg::TICK_US);
    endcase
    case (ctrl_r.stretch_sel)
      2'd0: str_ticks = 11'(incond_pkg::STR0_US / incond_pkg::TICK_US);
      2'd1: str_ticks = 11'(incond_pkg::STR1_US / incond_pkg::TICK_US);
      2'd2: str_ticks = 11'(incond_pkg::STR2_US / incond_pkg::TICK_US);
      default: str_ticks = 11'(incond_pkg::STR3_US / incond_pkg::TICK_US);
    endcase
  end

  // ----------------------------------------
  // per-channel filter and stretch
  // ----------------------------------------
  logic [N-1:0] filt_val; // accepted level after the filter
  logic [N-1:0] on_event; // one-cycle pulse on an accepted rising edge

  for (genvar c = 0; c < N; c++)
  begin : g_chan
    logic lvl_r, lvl_nxt; // accepted level
    logic [7:0] stab_r, stab_nxt; // ticks the raw level differed
    logic [10:0] hold_r, hold_nxt; // stretch ticks remaining

    // accept a new level only after it stayed stable
    always_comb
    begin
      lvl_nxt = lvl_r;
      stab_nxt = stab_r;
      hold_nxt = hold_r;
      if (in_pins[c] == lvl_r)
      begin
        stab_nxt = 8'h0; // glitch ended, restart the wait
      end
      else if (tick)
      begin
        if (stab_r + 8'h1 >= filt_ticks)
        begin
          lvl_nxt = in_pins[c];
          stab_nxt = 8'h0;
        end
        else
        begin
          stab_nxt = stab_r + 8'h1;
        end
      end
      if (lvl_nxt && !lvl_r)
      begin
        hold_nxt = str_ticks;
      end
      else if (tick && hold_r != 11'h0)
      begin
        hold_nxt = hold_r - 11'h1;
      end
    end

    // channel state registers
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        lvl_r <= 1'b0;
        stab_r <= 8'h0;
        hold_r <= 11'h0;
      end
      else
      begin
        lvl_r <= lvl_nxt;
        stab_r <= stab_nxt;
        hold_r <= hold_nxt;
      end
    end

    assign filt_val[c] = lvl_r;
    assign on_event[c] = lvl_nxt && !lvl_r;
    assign chan_value[c] = filt_val[c] || (hold_r != 11'h0);
  end

  // ----------------------------------------
  // inrush blanking of overcurrent
  // ----------------------------------------
  logic [9:0] inr_r, inr_nxt; // blanking ticks left
  logic oc_d_r, oc_d_nxt; // overcurrent seen last cycle
  logic oc_err_r, oc_err_nxt; // reported overcurrent

  // window opens on the rising edge of the excess current
  always_comb
  begin
    oc_d_nxt = overcurrent_in;
    inr_nxt = inr_r;
    if (overcurrent_in && !oc_d_r)
    begin
      inr_nxt = 10'(incond_pkg::INRUSH_TICKS);
    end
    else if (tick && inr_r != 10'h0)
    begin
      inr_nxt = inr_r - 10'h1;
    end
    oc_err_nxt = overcurrent_in && !(ctrl_r.inrush_enable && inr_nxt != 10'h0);
  end

  // inrush registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      inr_r <= 10'h0;
      oc_d_r <= 1'b0;
      oc_err_r <= 1'b0;
    end
    else
    begin
      inr_r <= inr_nxt;
      oc_d_r <= oc_d_nxt;
      oc_err_r <= oc_err_nxt;
    end
  end

  assign overcurrent_err = oc_err_r;

  // ----------------------------------------
  // disconnection of the attached device
  // ----------------------------------------
  // disc_sense flags the device, the signal line itself is not judged
  always_comb
  begin
    disc_err_nxt = disc_sense & {N{ctrl_r.disconnect_detect_enable}};
  end

  // ----------------------------------------
  // counters, threshold scan, save and restore
  // ----------------------------------------
  logic [AW-1:0] idx_r, idx_nxt; // channel under load or save
  logic [AW-1:0] scan_r, scan_nxt; // threshold read address
  logic [AW-1:0] scan_d_r; // channel whose threshold is on rdata
  logic [incond_pkg::THR_W-1:0] thr_rd; // threshold read data
  logic [31:0] save_r, save_nxt; // ticks since last save
  logic save_due; // save interval elapsed
  logic [25:0] thr_scaled; // threshold times one thousand
  logic thr_we; // legal threshold write

  thresh_mem #(.DEPTH(N), .WIDTH(incond_pkg::THR_W), .AW(AW)) u_thr
  (
    .clk(pclk),
    .we(thr_we),
    .waddr(paddr[AW+1:2]),
    .wdata(pwdata[incond_pkg::THR_W-1:0]),
    .raddr(scan_r),
    .rdata(thr_rd)
  );

  // values outside 1..65000 are dropped
  assign thr_we = wr_en && in_block(paddr, incond_pkg::OFF_THRESH) &&
                  pwdata[31:16] == 16'h0 && pwdata[15:0] >= incond_pkg::THR_MIN &&
                  pwdata[15:0] <= incond_pkg::THR_MAX;
  assign thr_scaled = 26'(thr_rd) * incond_pkg::THR_SCALE;
  assign save_due = save_r >= (ctrl_r.valve_unit ? 32'(SAVE_VALVE_TICKS - 1)
                                                 : 32'(SAVE_INPUT_TICKS - 1));

  // sequencer, counting, error compare and store requests
  always_comb
  begin
    seq_nxt = seq_r;
    idx_nxt = idx_r;
    count_nxt = count_r;
    save_nxt = save_r;
    scan_nxt = scan_r + AW'(1);
    cnt_err_nxt = cnt_err_r;
    nv_req = 1'b0;
    nv_we = 1'b0;
    nv_addr = idx_r;
    nv_wdata = count_r[idx_r];
    if (seq_r != incond_pkg::ST_LOAD)
    begin
      for (int i = 0; i < N; i++)
      begin
        if (on_event[i])
        begin
          count_nxt[i] = count_r[i] + 32'h1;
        end
      end
      if (tick)
      begin
        save_nxt = save_r + 32'h1;
      end
    end
    // zero threshold means never written
    if (ctrl_r.counter_enable && thr_rd != 16'h0 &&
        count_r[scan_d_r] > 32'(thr_scaled))
    begin
      cnt_err_nxt[scan_d_r] = 1'b1;
    end
    if (!ctrl_r.counter_enable)
    begin
      cnt_err_nxt = '0;
    end
    case (seq_r)
      incond_pkg::ST_LOAD:
      begin
        nv_req = 1'b1;
        if (nv_ack)
        begin
          count_nxt[idx_r] = nv_rdata; // resume from the saved value
          idx_nxt = idx_r + AW'(1);
          if (idx_r == AW'(N - 1))
          begin
            idx_nxt = '0;
            seq_nxt = incond_pkg::ST_RUN;
          end
        end
      end
      incond_pkg::ST_RUN:
      begin
        if (tick && save_due)
        begin
          save_nxt = 32'h0;
          seq_nxt = incond_pkg::ST_SAVE;
        end
      end
      incond_pkg::ST_SAVE:
      begin
        nv_req = 1'b1;
        nv_we = 1'b1;
        if (nv_ack)
        begin
          idx_nxt = idx_r + AW'(1);
          if (idx_r == AW'(N - 1))
          begin
            idx_nxt = '0;
            seq_nxt = incond_pkg::ST_RUN;
          end
        end
      end
      default:
      begin
        seq_nxt = incond_pkg::ST_LOAD;
      end
    endcase
  end

  // counter and sequencer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_r <= incond_pkg::ST_LOAD; // power-up restore first
      idx_r <= '0;
      scan_r <= '0;
      scan_d_r <= '0;
      count_r <= '0;
      save_r <= 32'h0;
      cnt_err_r <= '0;
      disc_err_r <= '0;
    end
    else
    begin
      seq_r <= seq_nxt;
      idx_r <= idx_nxt;
      scan_r <= scan_nxt;
      scan_d_r <= scan_r;
      count_r <= count_nxt;
      save_r <= save_nxt;
      cnt_err_r <= cnt_err_nxt;
      disc_err_r <= disc_err_nxt;
    end
  end

endmodule : input_conditioning_counter

/* rtl/thresh_mem.sv */
// small threshold memory, one write port and one registered read port
`timescale 1ns/100ps
module thresh_mem
#(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16,
  parameter int AW = 3
)
(
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [WIDTH-1:0] mem [DEPTH]; // no reset: zero threshold means unset only after write

  // write and registered read
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : thresh_mem

/* testbench/incond_asserts.sv */
// port assertions for the input conditioning block
`timescale 1ns/100ps
module incond_asserts
#(
  parameter int N = 8,
  parameter int AW = 3
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // field side
  input wire logic [N-1:0] chan_value,
  input wire logic overcurrent_in,
  input wire logic overcurrent_err,
  // store side
  input wire logic nv_req,
  input wire logic nv_we,
  input wire logic [AW-1:0] nv_addr,
  input wire logic nv_ack
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_acc = psel && penable && !pwrite; // read access phase

  chk_zero_wait: assert property (psel && penable |-> pready)
    else $error("apb access not answered");
  chk_unmapped_err: assert property (psel && penable && paddr == 8'h20 |-> pslverr)
    else $error("unmapped access without error");
  chk_thresh_wo: assert property (rd_acc && paddr == incond_pkg::OFF_THRESH |-> prdata == 32'h0)
    else $error("threshold readable");
  chk_input_read: assert property (rd_acc && paddr == incond_pkg::OFF_INPUT |-> prdata[N-1:0] == chan_value)
    else $error("channel values misread");
  chk_oc_cause: assert property (overcurrent_err |-> $past(overcurrent_in))
    else $error("overcurrent error without cause");
  chk_nv_hold: assert property (nv_req && !nv_ack |=> nv_req && $stable(nv_addr) && $stable(nv_we))
    else $error("store request dropped early");
  chk_nv_step: assert property (nv_req && nv_ack && nv_addr != AW'(N-1) |=> nv_req && nv_addr == $past(nv_addr) + 1'b1)
    else $error("store channel not stepped");
  chk_nv_done: assert property (nv_req && nv_ack && nv_addr == AW'(N-1) |=> !nv_req)
    else $error("store sequence overran");
  chk_load_start: assert property ($rose(presetn) |-> nv_req && !nv_we && nv_addr == '0)
    else $error("load not started at reset");
endmodule : incond_asserts

/* testbench/input_conditioning_counter_test.sv */
// self-checking bench for the input conditioning block
`timescale 1ns/100ps
module input_conditioning_counter_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, nv_wdata, nv_rdata;
  logic [7:0] in_pins, disc_sense, chan_value;
  logic overcurrent_in, overcurrent_err, nv_req, nv_we, nv_ack, slow;
  logic [2:0] nv_addr;
  int fails = 0;
  int total_checks = 0;

  input_conditioning_counter #(.TICK_CYCLES(10), .SAVE_VALVE_TICKS(50), .SAVE_INPUT_TICKS(80)) uut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_pins, .overcurrent_in,
    .disc_sense, .chan_value, .overcurrent_err, .nv_req, .nv_we, .nv_addr, .nv_wdata, .nv_ack, .nv_rdata);
  nv_store nv (.pclk, .presetn, .nv_req, .nv_we, .nv_addr, .nv_wdata, .nv_ack, .nv_rdata, .slow);

  // clock, 10 ns
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer, setup then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // wait as long as the slave needs, the watchdog ends a hang
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, x);
  endtask : rdc

  // raise one channel for len cycles
  task automatic hold_in(input int ch, input int len);
    in_pins[ch] <= 1'b1;
    repeat (len) @(posedge pclk);
    in_pins[ch] <= 1'b0;
  endtask : hold_in

  // reset values, restored counts, unmapped access
  task automatic t_reset();
    int n;
    logic [31:0] q;
    logic e;
    for (n = 0; n < 300 && nv_req !== 1'b0; n++) @(posedge pclk);
    rdc(incond_pkg::OFF_STATUS, 32'h2);
    rdc(incond_pkg::OFF_CTRL, 32'h00a);
    for (n = 0; n < 8; n++) rdc(incond_pkg::OFF_COUNT + 8'(4 * n), nv.mem[n]);
    rdc(incond_pkg::OFF_THRESH, 32'h0);
    apb(1'b0, 8'h20, 32'h0, q, e);
    check(e, 1'b1);
    $display("test reset done");
  endtask : t_reset

  // 1 ms filter: short pulse dropped, long one accepted late and counted
  task automatic t_filter();
    int n;
    wr(incond_pkg::OFF_CTRL, 32'h002);
    hold_in(0, 60);
    repeat (150) @(posedge pclk);
    check(chan_value[0], 1'b0);
    in_pins[0] <= 1'b1;
    for (n = 0; n < 200 && chan_value[0] !== 1'b1; n++) @(posedge pclk);
    check(n >= 85 && n < 200, 1'b1);
    rdc(incond_pkg::OFF_INPUT, 32'h1);
    in_pins[0] <= 1'b0;
    repeat (400) @(posedge pclk);
    rdc(incond_pkg::OFF_COUNT, 32'h1);
    $display("test filter done");
  endtask : t_filter

  // stretch codes 0 and 1 under the shortest filter
  task automatic t_stretch();
    int n, s;
    int len [2] = '{100, 1500};
    for (s = 0; s < 2; s++)
    begin
      wr(incond_pkg::OFF_CTRL, 32'(s) << 3);
      in_pins[3] <= 1'b1;
      for (n = 0; n < 50 && chan_value[3] !== 1'b1; n++) @(posedge pclk);
      in_pins[3] <= 1'b0;
      repeat (len[s] * 9 / 10) @(posedge pclk);
      check(chan_value[3], 1'b1);
      repeat (len[s] / 10 + 300) @(posedge pclk);
      check(chan_value[3], 1'b0);
    end
    $display("test stretch done");
  endtask : t_stretch

  // threshold scaling, out of range threshold, enable and clear
  task automatic t_counter();
    wr(incond_pkg::OFF_CTRL, 32'h000);
    wr(incond_pkg::OFF_THRESH + 8'h4, 32'd1);
    wr(incond_pkg::OFF_THRESH + 8'h8, 32'd65001);
    hold_in(1, 40);
    repeat (150) @(posedge pclk);
    rdc(incond_pkg::OFF_COUNT + 8'h4, 32'd1001);
    rdc(incond_pkg::OFF_CNT_ERR, 32'h0);
    wr(incond_pkg::OFF_CTRL, 32'h040);
    repeat (20) @(posedge pclk);
    rdc(incond_pkg::OFF_CNT_ERR, 32'h2);
    wr(incond_pkg::OFF_CTRL, 32'h000);
    rdc(incond_pkg::OFF_CNT_ERR, 32'h0);
    $display("test counter done");
  endtask : t_counter

  // overcurrent passes when blanking is off, held back for 100 ms when on
  task automatic t_inrush();
    overcurrent_in <= 1'b1;
    repeat (3) @(posedge pclk);
    check(overcurrent_err, 1'b1);
    overcurrent_in <= 1'b0;
    wr(incond_pkg::OFF_CTRL, 32'h020);
    overcurrent_in <= 1'b1;
    // blanking lasts the full inrush tick count, bench ticks are 10 cycles
    repeat (incond_pkg::INRUSH_TICKS * 10 - 100) @(posedge pclk);
    check(overcurrent_err, 1'b0);
    repeat (200) @(posedge pclk);
    check(overcurrent_err, 1'b1);
    overcurrent_in <= 1'b0;
    $display("test inrush done");
  endtask : t_inrush

  // disconnection flags only with the option on
  task automatic t_disc();
    disc_sense <= 8'h05;
    wr(incond_pkg::OFF_CTRL, 32'h000);
    rdc(incond_pkg::OFF_DISC_ERR, 32'h0);
    wr(incond_pkg::OFF_CTRL, 32'h080);
    rdc(incond_pkg::OFF_DISC_ERR, 32'h5);
    $display("test disconnect done");
  endtask : t_disc

  // cycles from the end of one save to the start of the next
  // interval runs from save start; a slow save of eight words takes 40 cycles
  task automatic gap(output int m);
    int n;
    for (n = 0; n < 2000 && !(nv_req === 1'b1 && nv_we === 1'b1); n++) @(posedge pclk);
    for (n = 0; n < 200 && nv_req !== 1'b0; n++) @(posedge pclk);
    for (m = 0; m < 2000 && nv_req !== 1'b1; m++) @(posedge pclk);
  endtask : gap

  // save intervals of both unit kinds with a slow store
  task automatic t_save();
    int m;
    slow <= 1'b1;
    wr(incond_pkg::OFF_CTRL, 32'h200);
    gap(m);
    check(m >= 450 && m <= 470, 1'b1);
    check(nv.mem[1], 32'd1001);
    wr(incond_pkg::OFF_CTRL, 32'h000);
    gap(m);
    gap(m);
    check(m >= 750 && m <= 770, 1'b1);
    $display("test save done");
  endtask : t_save

  // counts and verdict, then stop
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, overcurrent_in, slow} = '0;
    {paddr, pwdata, in_pins, disc_sense} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_filter();
    t_stretch();
    t_counter();
    t_inrush();
    t_disc();
    t_save();
    end_of_test();
  end

  // watchdog
  initial
  begin
    repeat (60000) @(posedge pclk);
    fails++;
    end_of_test();
  end
endmodule : input_conditioning_counter_test

bind input_conditioning_counter incond_asserts #(.N(N), .AW(AW)) chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .chan_value, .overcurrent_in, .overcurrent_err, .nv_req, .nv_we, .nv_addr,
  .nv_ack);

/* testbench/nv_store.sv */
// behavioural non-volatile count store
`timescale 1ns/100ps
module nv_store
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // store port
  input wire logic nv_req,
  input wire logic nv_we,
  input wire logic [2:0] nv_addr,
  input wire logic [31:0] nv_wdata,
  output logic nv_ack,
  output logic [31:0] nv_rdata,
  // long waits when high
  input wire logic slow
);
  logic [31:0] mem [8]; // saved counts
  int wait_q; // cycles waited on this word
  // preset counts, ch1 sits on a threshold of one thousand
  initial
  begin
    foreach (mem[i]) mem[i] = i;
    mem[1] = 32'h3e8;
    mem[2] = 32'h0400_0000;
  end
  // one-cycle ack after a short or long wait; data garbled when idle
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      nv_ack <= 1'b0;
      wait_q <= 0;
      nv_rdata <= 32'h5a5a_a5a5;
    end
    else if (nv_ack)
    begin
      if (nv_req && nv_we) mem[nv_addr] <= nv_wdata;
      nv_ack <= 1'b0;
      wait_q <= 0;
      nv_rdata <= ~nv_rdata;
    end
    else if (nv_req && wait_q >= (slow ? 3 : 0))
    begin
      nv_ack <= 1'b1;
      nv_rdata <= mem[nv_addr];
    end
    else
    begin
      wait_q <= nv_req ? wait_q + 1 : 0;
      nv_rdata <= ~nv_rdata;
    end
endmodule : nv_store
